// File: hw/fdchr_regs.svh
// Register offsets, field positions, reset values and timing figures of the floppy host register block.
// Assumes an 8-bit host I/O port that presents a 3-bit byte offset from an 8-byte aligned base.
`ifndef FDCHR_REGS_SVH
`define FDCHR_REGS_SVH

// =====================================================================
// Offsets
`define FDCHR_OFF_STATUS_A 3'h0
`define FDCHR_OFF_STATUS_B 3'h1
`define FDCHR_OFF_DIG_OUT 3'h2
`define FDCHR_OFF_TAPE_SEL 3'h3
`define FDCHR_OFF_MAIN_RATE 3'h4
`define FDCHR_OFF_FIFO 3'h5
`define FDCHR_OFF_DIG_IN_CFG 3'h7

// =====================================================================
// Fields and reset values
`define FDCHR_DOR_SEL_HI 1
`define FDCHR_DOR_SEL_LO 0
`define FDCHR_DOR_RESET_N 2
`define FDCHR_DOR_DMA_EN 3
`define FDCHR_DOR_MTR0 4
`define FDCHR_DOR_MOTOR_ON_B 5
`define FDCHR_DSR_SW_RESET 7
`define FDCHR_CMD_MFM 6
`define FDCHR_DOR_RST 8'h00
`define FDCHR_TDR_RST 4'h0
`define FDCHR_RATE_RST 2'h0
`define FDCHR_MISC_RST 4'h0
`define FDCHR_TDR_ENH_FILL 4'hf
`define FDCHR_UNMAPPED_READ 8'hff
`define FDCHR_RATE_HIGH_DENS 2'h0
`define FDCHR_RATE_ONE_MEG 2'h3

// =====================================================================
// Command opcodes and status values
`define FDCHR_OP_SPECIFY 5'h03
`define FDCHR_OP_WRITE 5'h05
`define FDCHR_OP_READ 5'h06
`define FDCHR_OP_RECAL 5'h07
`define FDCHR_OP_SENSE 5'h08
`define FDCHR_OP_SEEK 5'h0f
`define FDCHR_ST0_INVALID 8'h80
`define FDCHR_ST0_SEEK_END 8'h20
`define FDCHR_SECTOR_ONE 8'h01
`define FDCHR_SIZE_512 8'h02

// =====================================================================
// Timing
`define FDCHR_CLK_NS 40
`define FDCHR_STEP_NS 4000
`define FDCHR_EXEC_NS 2000

`endif

// File: hw/fdchr_pkg.sv
// Types shared by the floppy host register block.
// Assumes the constants header is compiled alongside.
`default_nettype none

package fdchr_pkg;

    // =====================================================================
    // Sequencer phases
    typedef enum logic [1:0] {
        FDCHR_IDLE,
        FDCHR_CMD,
        FDCHR_EXEC,
        FDCHR_RESULT
    } fdchr_state_e;

    // =====================================================================
    // Drive-side pin groups: inputs at raw pin level, outputs active high
    typedef struct packed {
        logic index_pin;
        logic trk0_pin;
        logic wp_pin;
        logic rdata_pin;
        logic disk_changed_pin;
    } fdchr_pins_s;

    typedef struct packed {
        logic drive_sel_a;
        logic motor_on_a;
        logic rate_out_lo;
        logic step;
        logic dir;
        logic head_sel;
        logic write_gate;
        logic mfm;
    } fdchr_drive_s;

endpackage

`default_nettype wire

// File: hw/fdchr_host_regs.sv
// Host register file and small command sequencer of a floppy disk controller.
// Assumes a same-clock byte I/O port (address, read and write strobes) and raw drive pins from outside.
`include "fdchr_regs.svh"
`default_nettype none

// Notes on behaviour
// - command byte bit 6 selects FM or MFM
// - floating drive pins read back as one
// - no media sense inputs, no dependence
// - only drive 0, motor 0, low rate driven
// - offsets 0 to 7, offset 6 empty
// - offsets 4 and 7 split read/write
// - other fields identical in both system modes
// - status A/B, extended input only extended
// - legacy input register: only disk change
// - write-only bits read back zero
// - thirteen of seventeen drive signals supported
module fdchr_host_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic extended_system_mode,
    input wire logic enhanced_tdr,
    input wire fdchr_pkg::fdchr_pins_s drive_pins,
    output logic [7:0] io_rdata,
    output var fdchr_pkg::fdchr_drive_s drive_out
);

    // =====================================================================
    // Timing counts
    localparam int STEP_CYC_I = (`FDCHR_STEP_NS + `FDCHR_CLK_NS - 1) / `FDCHR_CLK_NS;
    localparam int EXEC_CYC_I = (`FDCHR_EXEC_NS + `FDCHR_CLK_NS - 1) / `FDCHR_CLK_NS;
    localparam logic [7:0] STEP_CYC = 8'(STEP_CYC_I);
    localparam logic [7:0] EXEC_CYC = 8'(EXEC_CYC_I);

    // =====================================================================
    // Pin synchronisers
    // Only the second stage is read; the pins are asynchronous to clk.
    fdchr_pkg::fdchr_pins_s pins_s1_reg;
    fdchr_pkg::fdchr_pins_s pins_reg;

    always_ff @(posedge clk) begin
        pins_s1_reg <= drive_pins;
        pins_reg <= pins_s1_reg;
    end

    // =====================================================================
    // Host access decode
    logic wr_dor, wr_tdr, wr_dsr, wr_ccr, wr_fifo, rd_fifo;
    assign wr_dor = io_wr && io_addr == `FDCHR_OFF_DIG_OUT;
    assign wr_tdr = io_wr && io_addr == `FDCHR_OFF_TAPE_SEL;
    assign wr_dsr = io_wr && io_addr == `FDCHR_OFF_MAIN_RATE;
    assign wr_ccr = io_wr && io_addr == `FDCHR_OFF_DIG_IN_CFG;
    assign wr_fifo = io_wr && io_addr == `FDCHR_OFF_FIFO;
    assign rd_fifo = io_rd && io_addr == `FDCHR_OFF_FIFO;

    // =====================================================================
    // Host-written registers
    logic [7:0] dor_reg;
    logic [3:0] tdr_reg;
    logic [1:0] rate_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            dor_reg <= `FDCHR_DOR_RST;
        end else if (wr_dor) begin
            dor_reg <= io_wdata;
        end
    end

    // The exchange bits only exist in the enhanced layout; bits 7:4 are not stored.
    always_ff @(posedge clk) begin
        if (srst) begin
            tdr_reg <= `FDCHR_TDR_RST;
        end else if (wr_tdr) begin
            tdr_reg <= enhanced_tdr ? io_wdata[3:0] : {2'h0, io_wdata[1:0]};
        end
    end

    // Both the rate-select and the configuration writes steer one shared rate field.
    always_ff @(posedge clk) begin
        if (srst) begin
            rate_reg <= `FDCHR_RATE_RST;
        end else if (wr_dsr) begin
            // Precompensation and low-power settings are accepted but not kept, since nothing here uses them.
            rate_reg <= io_wdata[1:0];
        end else if (wr_ccr) begin
            rate_reg <= io_wdata[1:0];
        end
    end

    // The sequencer stays in reset while the controller reset bit is low or a software reset is written.
    logic seq_rst;
    assign seq_rst = srst || !dor_reg[`FDCHR_DOR_RESET_N] || (wr_dsr && io_wdata[`FDCHR_DSR_SW_RESET]);

    // =====================================================================
    // Command tables
    function automatic logic [3:0] cmd_len(input logic [4:0] op);
        unique case (op)
            `FDCHR_OP_READ, `FDCHR_OP_WRITE: cmd_len = 4'h9;
            `FDCHR_OP_SEEK, `FDCHR_OP_SPECIFY: cmd_len = 4'h3;
            `FDCHR_OP_RECAL: cmd_len = 4'h2;
            default: cmd_len = 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] res_len(input logic [4:0] op);
        unique case (op)
            `FDCHR_OP_READ, `FDCHR_OP_WRITE: res_len = 4'h7;
            `FDCHR_OP_SEEK, `FDCHR_OP_SPECIFY, `FDCHR_OP_RECAL: res_len = 4'h0;
            `FDCHR_OP_SENSE: res_len = 4'h2;
            default: res_len = 4'h1;
        endcase
    endfunction

    // =====================================================================
    // Command sequencer
    fdchr_pkg::fdchr_state_e state_reg;
    logic [4:0] op_reg;
    logic [7:0] hd_reg;
    logic [7:0] cyl_reg;
    logic [3:0] cnt_reg;
    logic [3:0] res_idx_reg;
    logic [7:0] st0_reg;
    logic [7:0] trk_reg;
    logic [7:0] tmr_reg;
    logic mfm_reg;
    logic step_reg;
    logic dir_reg;
    logic irq_reg;
    logic exec_done;
    logic is_seek;

    assign is_seek = op_reg == `FDCHR_OP_SEEK || op_reg == `FDCHR_OP_RECAL;
    // Recalibrate ends at the track-zero pin; the pin is active low.
    assign exec_done = is_seek ? (op_reg == `FDCHR_OP_RECAL ? !pins_reg.trk0_pin : trk_reg == cyl_reg)
                               : tmr_reg == 8'h00;

    always_ff @(posedge clk) begin
        if (seq_rst) begin
            state_reg <= fdchr_pkg::FDCHR_IDLE;
            op_reg <= 5'h00;
            hd_reg <= 8'h00;
            cyl_reg <= 8'h00;
            cnt_reg <= 4'h0;
            res_idx_reg <= 4'h0;
            st0_reg <= 8'h00;
            tmr_reg <= 8'h00;
            step_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else begin
            step_reg <= 1'b0;
            unique case (state_reg)
                fdchr_pkg::FDCHR_IDLE: begin
                    if (wr_fifo) begin
                        op_reg <= io_wdata[4:0];
                        cnt_reg <= 4'h1;
                        tmr_reg <= EXEC_CYC;
                        if (io_wdata[4:0] == `FDCHR_OP_SENSE) begin
                            // The pending flag clears on this edge, so its verdict is frozen into the status now.
                            if (!irq_reg) begin
                                st0_reg <= `FDCHR_ST0_INVALID;
                            end
                            res_idx_reg <= 4'h0;
                            state_reg <= fdchr_pkg::FDCHR_RESULT;
                        end else if (cmd_len(io_wdata[4:0]) == 4'h1) begin
                            st0_reg <= `FDCHR_ST0_INVALID;
                            res_idx_reg <= 4'h0;
                            state_reg <= fdchr_pkg::FDCHR_RESULT;
                        end else begin
                            state_reg <= fdchr_pkg::FDCHR_CMD;
                        end
                    end
                end
                fdchr_pkg::FDCHR_CMD: begin
                    if (wr_fifo) begin
                        if (cnt_reg == 4'h1) begin
                            hd_reg <= io_wdata;
                        end
                        if (cnt_reg == 4'h2) begin
                            cyl_reg <= io_wdata;
                        end
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg + 4'h1 == cmd_len(op_reg)) begin
                            state_reg <= fdchr_pkg::FDCHR_EXEC;
                            tmr_reg <= op_reg == `FDCHR_OP_SEEK || op_reg == `FDCHR_OP_RECAL ? 8'h00 : EXEC_CYC;
                        end
                    end
                end
                fdchr_pkg::FDCHR_EXEC: begin
                    if (exec_done) begin
                        st0_reg <= is_seek ? (`FDCHR_ST0_SEEK_END | {5'h00, hd_reg[2:0]}) : {5'h00, hd_reg[2:0]};
                        res_idx_reg <= 4'h0;
                        state_reg <= res_len(op_reg) == 4'h0 ? fdchr_pkg::FDCHR_IDLE : fdchr_pkg::FDCHR_RESULT;
                    end else if (is_seek && tmr_reg == 8'h00) begin
                        // One step pulse per step period, direction toward the target.
                        step_reg <= 1'b1;
                        dir_reg <= op_reg == `FDCHR_OP_SEEK && cyl_reg > trk_reg;
                        tmr_reg <= STEP_CYC - 8'h01;
                    end else begin
                        tmr_reg <= tmr_reg - 8'h01;
                    end
                end
                fdchr_pkg::FDCHR_RESULT: begin
                    if (rd_fifo) begin
                        res_idx_reg <= res_idx_reg + 4'h1;
                        if (res_idx_reg + 4'h1 == res_len(op_reg)) begin
                            state_reg <= fdchr_pkg::FDCHR_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // The recording method is latched from the first command byte.
    always_ff @(posedge clk) begin
        if (srst) begin
            mfm_reg <= 1'b0;
        end else if (wr_fifo && state_reg == fdchr_pkg::FDCHR_IDLE) begin
            mfm_reg <= io_wdata[`FDCHR_CMD_MFM];
        end
    end

    // Head position survives a controller reset; only a full reset or a completed recalibrate clears it.
    always_ff @(posedge clk) begin
        if (srst) begin
            trk_reg <= 8'h00;
        end else if (state_reg == fdchr_pkg::FDCHR_EXEC && is_seek && exec_done) begin
            trk_reg <= op_reg == `FDCHR_OP_RECAL ? 8'h00 : trk_reg;
        end else if (step_reg) begin
            trk_reg <= dir_reg ? trk_reg + 8'h01 : trk_reg - 8'h01;
        end
    end

    // Pending interrupt: a completion sets it and a sense command clears it; the set wins.
    always_ff @(posedge clk) begin
        if (seq_rst) begin
            irq_reg <= 1'b0;
        end else if (state_reg == fdchr_pkg::FDCHR_EXEC && exec_done) begin
            irq_reg <= 1'b1;
        end else if (wr_fifo && state_reg == fdchr_pkg::FDCHR_IDLE && io_wdata[4:0] == `FDCHR_OP_SENSE) begin
            irq_reg <= 1'b0;
        end
    end

    // =====================================================================
    // Read-back values
    logic request_for_master, dio;
    logic [7:0] main_status, result_byte, status_a, status_b, dig_in;

    assign request_for_master = !seq_rst && state_reg != fdchr_pkg::FDCHR_EXEC;
    assign dio = state_reg == fdchr_pkg::FDCHR_RESULT;
    assign main_status = {request_for_master, dio, state_reg == fdchr_pkg::FDCHR_EXEC && !dor_reg[`FDCHR_DOR_DMA_EN],
                          state_reg != fdchr_pkg::FDCHR_IDLE, 3'h0,
                          state_reg == fdchr_pkg::FDCHR_EXEC && is_seek};

    always_comb begin
        unique case (res_idx_reg)
            4'h0: result_byte = st0_reg;
            4'h1: result_byte = op_reg == `FDCHR_OP_SENSE ? trk_reg : 8'h00;
            4'h3: result_byte = cyl_reg;
            4'h4: result_byte = {7'h00, hd_reg[2]};
            4'h5: result_byte = `FDCHR_SECTOR_ONE;
            4'h6: result_byte = `FDCHR_SIZE_512;
            default: result_byte = 8'h00;
        endcase
    end

    // Pin-level bits are shown raw, so an undriven (pulled-up) pin reads as one.
    assign status_a = {irq_reg, 1'b0, drive_out.step, pins_reg.trk0_pin, drive_out.head_sel,
                       pins_reg.index_pin, pins_reg.wp_pin, drive_out.dir};
    // The second motor bit only reflects the stored control bit; no pin is driven from it.
    assign status_b = {2'h0, dor_reg[`FDCHR_DOR_SEL_HI:`FDCHR_DOR_SEL_LO] == 2'h0, 1'b0,
                       pins_reg.rdata_pin, drive_out.write_gate, dor_reg[`FDCHR_DOR_MOTOR_ON_B],
                       dor_reg[`FDCHR_DOR_MTR0]};
    assign dig_in = extended_system_mode ?
                    {pins_reg.disk_changed_pin, 4'h0, rate_reg,
                     !(rate_reg == `FDCHR_RATE_HIGH_DENS || rate_reg == `FDCHR_RATE_ONE_MEG)}
                    : {pins_reg.disk_changed_pin, 7'h00};

    // Reads answer one cycle after the strobe; write-only registers are never returned.
    always_ff @(posedge clk) begin
        if (srst || !io_rd) begin
            io_rdata <= 8'h00;
        end else begin
            unique case (io_addr)
                `FDCHR_OFF_STATUS_A: io_rdata <= extended_system_mode ? status_a : `FDCHR_UNMAPPED_READ;
                `FDCHR_OFF_STATUS_B: io_rdata <= extended_system_mode ? status_b : `FDCHR_UNMAPPED_READ;
                `FDCHR_OFF_DIG_OUT: io_rdata <= dor_reg;
                `FDCHR_OFF_TAPE_SEL: io_rdata <= enhanced_tdr ? {`FDCHR_TDR_ENH_FILL, tdr_reg} : {4'h0, tdr_reg};
                `FDCHR_OFF_MAIN_RATE: io_rdata <= main_status;
                `FDCHR_OFF_FIFO: io_rdata <= dio ? result_byte : 8'h00;
                `FDCHR_OFF_DIG_IN_CFG: io_rdata <= dig_in;
                default: io_rdata <= `FDCHR_UNMAPPED_READ;
            endcase
        end
    end

    // =====================================================================
    // Drive outputs
    // No second select, second motor or high rate pin exists, and nothing reads media sense.
    always_ff @(posedge clk) begin
        if (seq_rst) begin
            drive_out <= '0;
        end else begin
            drive_out.drive_sel_a <= dor_reg[`FDCHR_DOR_SEL_HI:`FDCHR_DOR_SEL_LO] == 2'h0;
            drive_out.motor_on_a <= dor_reg[`FDCHR_DOR_MTR0];
            drive_out.rate_out_lo <= rate_reg[0];
            drive_out.step <= step_reg;
            drive_out.dir <= dir_reg;
            drive_out.head_sel <= hd_reg[2];
            drive_out.write_gate <= state_reg == fdchr_pkg::FDCHR_EXEC && op_reg == `FDCHR_OP_WRITE;
            drive_out.mfm <= mfm_reg;
        end
    end

endmodule

`default_nettype wire

// File: test/fdchr_host_regs_chk.sv
// Concurrent checks on the ports of the floppy host register block.
// Assumes it is bound to that block and sees nothing but its ports.
`default_nettype none

module fdchr_host_regs_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic extended_system_mode,
    input wire logic enhanced_tdr,
    input wire fdchr_pkg::fdchr_pins_s drive_pins,
    input wire logic [7:0] io_rdata,
    input wire fdchr_pkg::fdchr_drive_s drive_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // =====================================================================
    // Host access steps
    sequence s_dor_wr; io_wr && io_addr == 3'h2; endsequence
    sequence s_dor_rd; io_rd && io_addr == 3'h2; endsequence
    sequence s_hold; io_wr && io_addr == 3'h2 && !io_wdata[2]; endsequence
    sequence s_msr_rd; io_rd && io_addr == 3'h4; endsequence

    // =====================================================================
    // Properties
    property p_idle_zero; !io_rd |=> io_rdata == 8'h00; endproperty
    property p_off6; io_rd && io_addr == 3'h6 |=> io_rdata == 8'hff; endproperty
    property p_legacy_sab; io_rd && io_addr[2:1] == 2'h0 && !extended_system_mode |=> io_rdata == 8'hff; endproperty
    property p_dir_legacy; io_rd && io_addr == 3'h7 && !extended_system_mode |=> io_rdata[6:0] == 7'h00; endproperty
    property p_sa_res; io_rd && io_addr == 3'h0 && extended_system_mode |=> io_rdata[6] == 1'b0; endproperty
    property p_dor_back; s_dor_wr ##1 !io_wr ##1 s_dor_rd |=> io_rdata[5:0] == $past(io_wdata[5:0], 3); endproperty
    property p_drive_hold; s_hold |=> ##1 drive_out == 8'h00; endproperty
    property p_sel_a; io_wr && io_addr == 3'h2 && io_wdata[5:0] == 6'h14 |=> ##1 drive_out.drive_sel_a && drive_out.motor_on_a;
    endproperty
    property p_no_sel_b; io_wr && io_addr == 3'h2 && io_wdata[1:0] == 2'h1 |=> ##1 !drive_out.drive_sel_a; endproperty
    property p_rqm_hold; s_hold ##1 (!io_wr) [*2] ##1 s_msr_rd |=> io_rdata == 8'h00; endproperty

    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero without a read");
    a_off6: assert property (p_off6) else $error("empty offset did not read all ones");
    a_legacy_sab: assert property (p_legacy_sab) else $error("status A or B visible in legacy mode");
    a_dir_legacy: assert property (p_dir_legacy) else $error("legacy digital input low bits not zero");
    a_sa_res: assert property (p_sa_res) else $error("status A reserved bit set");
    a_dor_back: assert property (p_dor_back) else $error("digital output read back differs");
    a_drive_hold: assert property (p_drive_hold) else $error("drive outputs active during controller reset");
    a_sel_a: assert property (p_sel_a) else $error("drive 0 select or motor not driven");
    a_no_sel_b: assert property (p_no_sel_b) else $error("drive 0 selected while drive 1 chosen");
    a_rqm_hold: assert property (p_rqm_hold) else $error("main status not zero in controller reset");
endmodule

bind fdchr_host_regs fdchr_host_regs_chk u_fdchr_host_regs_chk (.clk(clk), .srst(srst), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .extended_system_mode(extended_system_mode),
    .enhanced_tdr(enhanced_tdr), .drive_pins(drive_pins), .io_rdata(io_rdata), .drive_out(drive_out));

`default_nettype wire

// File: test/fdchr_drive_model.sv
// Behavioural floppy drive: head position, index and read data lines.
// Assumes pull-ups on every drive line, so a deselected or floating drive reads all ones.
`default_nettype none

module fdchr_drive_model (
    input wire logic clk,
    input wire fdchr_pkg::fdchr_drive_s drive_out,
    input wire logic floating,
    input wire logic disk_chg,
    output var fdchr_pkg::fdchr_pins_s drive_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] track_reg = 8'h00;
    logic [5:0] rev_reg = 6'h00;

    // =====================================================================
    // Head and spindle
    always_ff @(posedge clk) begin
        rev_reg <= rev_reg + 6'h01;
        if (drive_out.step) begin
            if (drive_out.dir) begin
                track_reg <= track_reg + 8'h01;
            end else if (track_reg != 8'h00) begin
                track_reg <= track_reg - 8'h01;
            end
        end
    end

    // A deselected drive releases its lines, which the pull-ups then take high.
    always_comb begin
        if (floating || !drive_out.drive_sel_a) begin
            drive_pins = 5'h1f;
        end else begin
            drive_pins.index_pin = rev_reg != 6'h00;
            drive_pins.trk0_pin = track_reg != 8'h00;
            drive_pins.wp_pin = 1'b1;
            drive_pins.rdata_pin = rev_reg[0];
            drive_pins.disk_changed_pin = disk_chg;
        end
    end
endmodule

`default_nettype wire

// File: test/tb_fdchr_host_regs.sv
// Self-checking bench for the floppy host register block.
// Assumes the drive model on the pins and the checker bound to the block.
`default_nettype none

module tb_fdchr_host_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, io_rd, io_wr, extended_system_mode, enhanced_tdr, floating, disk_chg;
    logic [2:0] io_addr;
    logic [7:0] io_wdata, io_rdata, v;
    fdchr_pkg::fdchr_pins_s drive_pins;
    fdchr_pkg::fdchr_drive_s drive_out;
    int miscompares = 0;
    int checked = 0;
    int steps = 0;

    fdchr_host_regs u_fdchr_host_regs (.clk(clk), .srst(srst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .extended_system_mode(extended_system_mode), .enhanced_tdr(enhanced_tdr),
        .drive_pins(drive_pins), .io_rdata(io_rdata), .drive_out(drive_out));
    fdchr_drive_model u_fdchr_drive_model (.clk(clk), .drive_out(drive_out), .floating(floating),
        .disk_chg(disk_chg), .drive_pins(drive_pins));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (drive_out.step === 1'b1) steps++;

    // =====================================================================
    // Host cycles and comparison
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset_state();
        chk("drive_out", 8'h00, drive_out);
        rd(3'h2, v); chk("digital_output", 8'h00, v);
        rd(3'h4, v); chk("main_status held", 8'h00, v);
        wr(3'h6, 8'h00); rd(3'h6, v); chk("offset 6", 8'hff, v);
        rd(3'h0, v); chk("legacy status_a", 8'hff, v);
        rd(3'h1, v); chk("legacy status_b", 8'hff, v);
        rd(3'h7, v); chk("legacy digital_input", 8'h80, v);
        extended_system_mode = 1'b1;
        rd(3'h0, v); chk("status_a floating", 8'h16, v);
        rd(3'h7, v); chk("digital_input ext", 8'h80, v);
    endtask
    task automatic t_dor();
        wr(3'h2, 8'h14); @(negedge clk);
        chk("drive 0 on", 8'h03, {6'h00, drive_out.drive_sel_a, drive_out.motor_on_a});
        rd(3'h2, v); chk("digital_output", 8'h14, v);
        rd(3'h4, v); chk("main_status idle", 8'h80, v);
        wr(3'h2, 8'h25); @(negedge clk);
        chk("drive 1 ignored", 8'h00, {6'h00, drive_out.drive_sel_a, drive_out.motor_on_a});
        repeat (3) @(negedge clk);
        rd(3'h1, v); chk("status_b", 8'h0a, v);
    endtask
    task automatic t_rate();
        for (int r = 0; r < 4; r++) begin
            wr((r % 2) ? 3'h4 : 3'h7, 8'(r)); @(negedge clk);
            rd(3'h7, v); chk("digital_input rate", {1'b1, 4'h0, 2'(r), 1'(r == 1 || r == 2)}, v);
            chk("rate_out_lo", 8'(r % 2), {7'h00, drive_out.rate_out_lo});
            rd(3'h4, v); chk("main_status not rate", 8'h80, v);
        end
        wr(3'h7, 8'h00);
    endtask
    task automatic t_tdr();
        wr(3'h3, 8'hff); rd(3'h3, v); chk("tape_drive_select", 8'h03, v);
        enhanced_tdr = 1'b1;
        wr(3'h3, 8'hf9); rd(3'h3, v); chk("tape_drive_select enh", 8'hf9, v);
        enhanced_tdr = 1'b0;
    endtask
    task automatic t_sense_mfm();
        wr(3'h2, 8'h14); rd(3'h2, v); chk("digital_output ready", 8'h14, v);
        floating = 1'b0; disk_chg = 1'b0; repeat (4) @(negedge clk);
        rd(3'h7, v); chk("disk_changed low", 8'h00, v);
        wr(3'h5, 8'h48); @(negedge clk); chk("mfm", 8'h01, {7'h00, drive_out.mfm});
        rd(3'h4, v); chk("main_status result", 8'h03, {6'h00, v[7:6]});
        rd(3'h5, v); chk("sense st0", 8'h80, v);
        rd(3'h5, v); chk("sense track", 8'h00, v);
        wr(3'h5, 8'h08); @(negedge clk); chk("fm", 8'h00, {7'h00, drive_out.mfm});
        rd(3'h5, v); rd(3'h5, v);
    endtask
    task automatic t_seek();
        steps = 0;
        wr(3'h5, 8'h0f); wr(3'h5, 8'h00); wr(3'h5, 8'h02);
        rd(3'h4, v); chk("rqm in exec", 8'h00, {7'h00, v[7]});
        for (int i = 0; i < 60 && !v[7]; i++) begin
            repeat (8) @(negedge clk);
            rd(3'h4, v);
        end
        chk("step pulses", 8'h02, 8'(steps));
        wr(3'h5, 8'h08);
        rd(3'h5, v); chk("sense st0", 8'h20, v);
        rd(3'h5, v); chk("sense track", 8'h02, v);
        steps = 0;
        wr(3'h5, 8'h07); wr(3'h5, 8'h00); rd(3'h4, v);
        for (int i = 0; i < 60 && !v[7]; i++) begin
            repeat (8) @(negedge clk);
            rd(3'h4, v);
        end
        chk("recal step pulses", 8'h02, 8'(steps));
        wr(3'h5, 8'h08);
        rd(3'h5, v); chk("recal st0", 8'h20, v);
        rd(3'h5, v); chk("recal track", 8'h00, v);
    endtask
    task automatic t_hold();
        wr(3'h2, 8'h10); @(negedge clk);
        chk("drive_out held", 8'h00, drive_out);
        rd(3'h4, v); chk("main_status held", 8'h00, v);
        wr(3'h5, 8'h08); rd(3'h5, v); chk("fifo ignored", 8'h00, v);
    endtask

    initial begin
        {io_rd, io_wr, extended_system_mode, enhanced_tdr, disk_chg} = 5'h00;
        floating = 1'b1;
        io_addr = 3'h0;
        io_wdata = 8'h00;
        srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        t_reset_state();
        t_dor();
        t_rate();
        t_tdr();
        t_sense_mfm();
        t_seek();
        t_hold();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule

`default_nettype wire
